//--- verilog/fcps_top.sv
`timescale 1ns/10ps
// Functional notes
// - bit 10 picks input frame pulse polarity
// - bit 9 aligns clock c edge to boundary
// - bit 5 aligns clock a edge to boundary
// - bit 4 picks frame pulse a polarity
// - bit 6 set gives positive pulse b
module fcps_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [fcps_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fcps_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fcps_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fcps_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial bus timing
  input wire logic input_frame_pulse,
  output logic output_clock_a,
  output logic output_clock_b,
  output logic output_clock_c,
  output logic output_frame_pulse_a,
  output logic output_frame_pulse_b,
  output logic output_frame_pulse_c
);
  import fcps_pkg::*;

  // address decode shared by the read and write paths
  function automatic logic [1:0] reg_sel(input logic [AXI_AW-1:0] a);
    logic [1:0] s;
    s = SEL_NONE;
    if (a[AXI_AW-1:2] == IDX_TIMING_CTL) s = SEL_CTL;
    else if (a[AXI_AW-1:2] == IDX_STATUS) s = SEL_STAT;
    return s;
  endfunction : reg_sel

  // reset release through two flops
  logic rst_m_r; // first stage
  logic rst_sync_b; // released copy
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_sync_b <= rst_m_r;
    end
  end

  // ---------------- register bus state ----------------
  logic [CTL_W-1:0] cr_r, cr_nxt; // timing_polarity_control
  logic aw_h_r, aw_h_nxt; // write address held
  logic w_h_r, w_h_nxt; // write data held
  logic [AXI_AW-1:0] awaddr_r, awaddr_nxt;
  logic [AXI_DW-1:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [AXI_DW-1:0] rdata_nxt;
  logic [STAT_CNT_W-1:0] frame_cnt_r; // boundaries seen, wraps
  logic seen_r; // at least one boundary seen

  // bus next-state: take aw and w in either order, answer after both
  always_comb begin
    logic [CTL_W-1:0] wv;
    wv = '0;
    cr_nxt = cr_r;
    aw_h_nxt = aw_h_r;
    w_h_nxt = w_h_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = s_axi_bvalid;
    bresp_nxt = s_axi_bresp;
    rvalid_nxt = s_axi_rvalid;
    rresp_nxt = s_axi_rresp;
    rdata_nxt = s_axi_rdata;
    // response taken
    if (s_axi_bvalid && s_axi_bready) bvalid_nxt = 1'b0;
    if (s_axi_rvalid && s_axi_rready) rvalid_nxt = 1'b0;
    // capture address and data
    if (s_axi_awvalid && s_axi_awready) begin
      aw_h_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_h_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    // perform write once both halves are held
    if (aw_h_r && w_h_r && !s_axi_bvalid) begin
      aw_h_nxt = 1'b0;
      w_h_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      if (reg_sel(awaddr_r) == SEL_CTL) begin
        wv = cr_r;
        if (wstrb_r[0]) wv[7:0] = wdata_r[7:0];
        if (wstrb_r[1]) wv[15:8] = wdata_r[15:8];
        cr_nxt = wv & CTL_WMASK; // bits 11 to 4 only (polarity bits and bit 11), rest read zero
        bresp_nxt = RESP_OKAY;
      end else if (reg_sel(awaddr_r) == SEL_STAT) begin
        bresp_nxt = RESP_OKAY; // status ignores writes
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    // read: answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = '0;
      case (reg_sel(s_axi_araddr))
        SEL_CTL: rdata_nxt[CTL_W-1:0] = cr_r;
        SEL_STAT: begin
          rdata_nxt[STAT_CNT_W-1:0] = frame_cnt_r;
          rdata_nxt[STAT_BIT_SEEN] = seen_r;
        end
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_h_nxt && !bvalid_nxt;
    wready_nxt = !w_h_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // bus registers
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cr_r <= CTL_RESET;
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      cr_r <= cr_nxt;
      aw_h_r <= aw_h_nxt;
      w_h_r <= w_h_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
    end
  end

  // ---------------- frame boundary and bit clock ----------------
  logic fp_prev_r, fp_prev_nxt; // last sampled input pulse
  logic boundary; // frame boundary this cycle
  logic [DIV_W-1:0] div_r, div_nxt; // half period divider
  logic base_r, base_nxt; // internal bit clock, falls at boundary
  logic pulse_r, pulse_nxt; // frame pulse active
  logic [1:0] phalf_r, phalf_nxt; // half periods left in pulse
  logic [STAT_CNT_W-1:0] frame_cnt_nxt;
  logic seen_nxt;
  logic half_tick; // one-cycle enable per half period
  logic edge_due_r, edge_due_nxt; // boundary seen last cycle, clock falls now

  // boundary is the edge into the active level chosen by software
  assign boundary = (input_frame_pulse == cr_r[BIT_IN_FP]) && (fp_prev_r != cr_r[BIT_IN_FP]);
  assign half_tick = (div_r == DIV_LAST);

  // timing next-state: boundary lifts the bit clock, the step after it falls and starts the pulse
  always_comb begin
    fp_prev_nxt = input_frame_pulse;
    edge_due_nxt = boundary;
    div_nxt = half_tick ? '0 : div_r + 1'b1;
    base_nxt = half_tick ? ~base_r : base_r;
    pulse_nxt = pulse_r;
    phalf_nxt = phalf_r;
    frame_cnt_nxt = frame_cnt_r;
    seen_nxt = seen_r;
    if (pulse_r && half_tick) begin
      phalf_nxt = phalf_r - 1'b1;
      if (phalf_r == 2'h1) pulse_nxt = 1'b0;
    end
    if (boundary) begin
      // lift first so the next step is a true falling edge; a boundary that
      // lands mid-phase therefore leaves one short clock phase
      div_nxt = '0;
      base_nxt = 1'b1;
      frame_cnt_nxt = frame_cnt_r + 1'b1;
      seen_nxt = 1'b1;
    end
    if (edge_due_r) begin
      div_nxt = '0;
      base_nxt = 1'b0;
      pulse_nxt = 1'b1;
      phalf_nxt = PULSE_HALVES;
    end
  end

  // timing registers; idle input level is the inactive one after reset
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fp_prev_r <= 1'b1;
      edge_due_r <= 1'b0;
      div_r <= '0;
      base_r <= 1'b0;
      pulse_r <= 1'b0;
      phalf_r <= '0;
      frame_cnt_r <= '0;
      seen_r <= 1'b0;
    end else begin
      fp_prev_r <= fp_prev_nxt;
      edge_due_r <= edge_due_nxt;
      div_r <= div_nxt;
      base_r <= base_nxt;
      pulse_r <= pulse_nxt;
      phalf_r <= phalf_nxt;
      frame_cnt_r <= frame_cnt_nxt;
      seen_r <= seen_nxt;
    end
  end

  // ---------------- three output pairs ----------------
  logic [2:0] ck_pol, fp_pol, ck_o, fp_o;
  assign ck_pol = {cr_r[BIT_CK_C], cr_r[BIT_CK_B], cr_r[BIT_CK_A]};
  assign fp_pol = {cr_r[BIT_FP_C], cr_r[BIT_FP_B], cr_r[BIT_FP_A]};

  // one registered stage per pair
  for (genvar g = 0; g < 3; g++) begin : g_out
    fcps_out_stage u_stage (
      .clk_sys(clk_sys),
      .rst_sync_b(rst_sync_b),
      .base_clk(base_nxt),
      .pulse_act(pulse_nxt),
      .clk_pol(ck_pol[g]),
      .pulse_pol(fp_pol[g]),
      .clk_out(ck_o[g]),
      .pulse_out(fp_o[g])
    );
  end

  assign output_clock_a = ck_o[0];
  assign output_clock_b = ck_o[1];
  assign output_clock_c = ck_o[2];
  assign output_frame_pulse_a = fp_o[0];
  assign output_frame_pulse_b = fp_o[1];
  assign output_frame_pulse_c = fp_o[2];

  // ---------------- checks ----------------
  // step at which the clock falls and the pulse starts
  sequence seq_boundary;
    edge_due_r;
  endsequence
  sequence seq_stable_ctl;
    ##1 $stable(cr_r);
  endsequence

  chk_in_frame_decode: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (input_frame_pulse == cr_r[BIT_IN_FP]) && ($past(input_frame_pulse) != cr_r[BIT_IN_FP]) && $stable(cr_r)
      |-> ##1 (edge_due_r && frame_cnt_r == $past(frame_cnt_r) + 1'b1) ##1 pulse_r)
    else $error("input frame edge not decoded");
  chk_clk_c_align: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    seq_boundary ##0 seq_stable_ctl |-> (output_clock_c == cr_r[BIT_CK_C]) && ($past(output_clock_c) != cr_r[BIT_CK_C]))
    else $error("clock c edge misaligned");
  chk_clk_a_align: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    seq_boundary ##0 seq_stable_ctl |-> (output_clock_a == cr_r[BIT_CK_A]) ##1 (output_clock_a == cr_r[BIT_CK_A]))
    else $error("clock a edge misaligned");
  chk_pulse_a_level: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    seq_boundary ##0 seq_stable_ctl |-> (output_frame_pulse_a == cr_r[BIT_FP_A]))
    else $error("pulse a polarity wrong");
  chk_pulse_b_pos: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    seq_boundary ##0 (cr_r[BIT_FP_B] ##1 cr_r[BIT_FP_B]) |-> output_frame_pulse_b)
    else $error("pulse b not positive");
  chk_pulse_bc_neg: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    seq_boundary ##0 (!cr_r[BIT_FP_B] && !cr_r[BIT_FP_C] ##1 !cr_r[BIT_FP_B] && !cr_r[BIT_FP_C])
      |-> !output_frame_pulse_b && !output_frame_pulse_c)
    else $error("pulse b or c not negative");
  chk_pulse_c_pos: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    seq_boundary ##0 (cr_r[BIT_FP_C] ##1 cr_r[BIT_FP_C]) |-> output_frame_pulse_c)
    else $error("pulse c not positive");
  chk_pulse_a_idle: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !pulse_nxt |=> (output_frame_pulse_a != $past(cr_r[BIT_FP_A])))
    else $error("pulse a idle level wrong");
  chk_pulse_b_idle: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !pulse_nxt |=> (output_frame_pulse_b != $past(cr_r[BIT_FP_B])))
    else $error("pulse b idle level wrong");
  chk_pulse_c_idle: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !pulse_nxt |=> (output_frame_pulse_c != $past(cr_r[BIT_FP_C])))
    else $error("pulse c idle level wrong");
endmodule : fcps_top

//--- verilog/fcps_out_stage.sv
`timescale 1ns/10ps
package fcps_pkg;
  // bus widths
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_TIMING_CTL = 10'h001;
  localparam logic [9:0] IDX_STATUS = 10'h002;
  // control register layout
  localparam int CTL_W = 16;
  localparam logic [CTL_W-1:0] CTL_RESET = 16'h0000;
  localparam logic [CTL_W-1:0] CTL_WMASK = 16'h0ff0;
  localparam int BIT_IN_FP = 10;
  localparam int BIT_CK_C = 9;
  localparam int BIT_FP_C = 8;
  localparam int BIT_CK_B = 7;
  localparam int BIT_FP_B = 6;
  localparam int BIT_CK_A = 5;
  localparam int BIT_FP_A = 4;
  // status register layout
  localparam int STAT_CNT_W = 8;
  localparam int STAT_BIT_SEEN = 8;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing: half period of the internal bit clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_HALF_NS = 122;
  localparam int HALF_CYC = (BIT_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : BIT_HALF_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);
  // frame pulse lasts this many half periods
  localparam logic [1:0] PULSE_HALVES = 2'h2;
  // selector codes from the address decoder
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTL = 2'h1;
  localparam logic [1:0] SEL_STAT = 2'h2;
endpackage : fcps_pkg

// one output pair: clock and frame pulse with their polarity applied
module fcps_out_stage (
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  input wire logic base_clk,
  input wire logic pulse_act,
  input wire logic clk_pol,
  input wire logic pulse_pol,
  output logic clk_out,
  output logic pulse_out
);
  logic clk_nxt; // next output clock level
  logic pulse_nxt; // next output pulse level

  // base clock falls at the boundary, so inverting moves a rising edge there
  always_comb begin
    clk_nxt = base_clk ^ clk_pol;
    pulse_nxt = pulse_pol ? pulse_act : ~pulse_act;
  end

  // register the pins; idle pulse level is high until the first update
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      clk_out <= 1'b0;
      pulse_out <= 1'b1;
    end else begin
      clk_out <= clk_nxt;
      pulse_out <= pulse_nxt;
    end
  end
endmodule : fcps_out_stage

//--- verif/fcps_frame_src.sv
`timescale 1ns/10ps
// far side: frame pulse source and observer of the timing outputs
module fcps_frame_src (
  input wire logic clk_sys,
  input wire logic pol_in, // active level of the frame pulse
  input wire logic fire, // one-cycle request for a frame
  input wire logic [5:0] outs, // clocks a b c, then pulses a b c
  output logic input_frame_pulse,
  output logic obs_v,
  output logic [5:0] obs_d,
  output logic busy
);
  logic [5:0] cnt_r = 6'h0; // cycles since the frame began
  // two cycles at the active level, otherwise idle at the inactive level
  assign input_frame_pulse = (cnt_r != 6'h0 && cnt_r < 6'h3) ? pol_in : ~pol_in;
  assign busy = (cnt_r != 6'h0);
  // frame timing and sampling of the outputs
  always @(posedge clk_sys) begin
    obs_v <= 1'b0;
    if (fire && cnt_r == 6'h0) begin
      cnt_r <= 6'h1;
    end else if (cnt_r != 6'h0) begin
      cnt_r <= (cnt_r == 6'd40) ? 6'h0 : cnt_r + 6'h1;
    end
    // just after the boundary: clocks and pulses
    if (cnt_r == 6'h3) begin
      obs_v <= 1'b1;
      obs_d <= outs;
    end
    // long after: pulses only, clocks masked
    if (cnt_r == 6'd33) begin
      obs_v <= 1'b1;
      obs_d <= {3'h0, outs[2:0]};
    end
  end
endmodule : fcps_frame_src

//--- verif/tb.sv
`timescale 1ns/10ps
// self-checking bench for the polarity select block
module tb;
  import fcps_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [AXI_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic input_frame_pulse, output_clock_a, output_clock_b, output_clock_c;
  logic output_frame_pulse_a, output_frame_pulse_b, output_frame_pulse_c;
  logic pol_in = 1'b0, fire = 1'b0, obs_v, busy;
  logic [5:0] obs_d;
  logic [33:0] exp_q[$]; // expected results, oldest first
  int miscompares = 0, n_tests = 0;
  localparam logic [AXI_AW-1:0] A_CTL = {IDX_TIMING_CTL, 2'b00};
  localparam logic [AXI_AW-1:0] A_STAT = {IDX_STATUS, 2'b00};
  // 50 mhz clock
  always #10 clk_sys = ~clk_sys;
  fcps_top dut_u (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .input_frame_pulse, .output_clock_a, .output_clock_b, .output_clock_c,
    .output_frame_pulse_a, .output_frame_pulse_b, .output_frame_pulse_c);
  fcps_frame_src far_u (.clk_sys, .pol_in, .fire, .outs({output_clock_a, output_clock_b, output_clock_c,
    output_frame_pulse_a, output_frame_pulse_b, output_frame_pulse_c}), .input_frame_pulse, .obs_v, .obs_d, .busy);
  // compare and count
  task check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task end_of_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // results are matched against the oldest note
  always @(posedge clk_sys) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (obs_v === 1'b1) check({28'h0, obs_d}, exp_q.pop_front());
  end
  // bus write, both channels offered together
  task axi_wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h3;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    check({32'h0, s_axi_bresp}, {32'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge clk_sys); // no back-to-back reassignment of bready
  endtask : axi_wr
  // bus read, the watcher compares the data
  task axi_rd(input logic [AXI_AW-1:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys); // no back-to-back reassignment of rready
  endtask : axi_rd
  // one frame with the given control value, early and late samples
  task frame(input logic [15:0] v);
    pol_in <= v[BIT_IN_FP];
    repeat (40) @(posedge clk_sys);
    exp_q.push_back({28'h0, v[BIT_CK_A], v[BIT_CK_B], v[BIT_CK_C], v[BIT_FP_A], v[BIT_FP_B], v[BIT_FP_C]});
    exp_q.push_back({31'h0, ~v[BIT_FP_A], ~v[BIT_FP_B], ~v[BIT_FP_C]});
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    do @(posedge clk_sys); while (busy === 1'b1);
  endtask : frame
  // main sequence
  initial begin
    logic [15:0] v;
    void'($urandom(32'heed169d6));
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    axi_rd(A_CTL, {RESP_OKAY, 16'h0, CTL_RESET});
    axi_rd(12'h0fc, {RESP_SLVERR, 32'h0});
    axi_wr(12'h0fc, 32'h0000_07f0, RESP_SLVERR);
    // all ones, all zeros, then random polarity sets
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 16'h07f0 : (i == 1) ? 16'h0000 : 16'($urandom()) & 16'h07f0;
      axi_wr(A_CTL, {16'h0, v}, RESP_OKAY);
      axi_rd(A_CTL, {RESP_OKAY, 16'h0, v});
      frame(v);
    end
    // status ignores writes and counts the ten boundaries
    axi_wr(A_STAT, 32'h0000_0000, RESP_OKAY);
    axi_rd(A_STAT, {RESP_OKAY, 32'h0000_010a});
    end_of_test();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    end_of_test();
  end
endmodule : tb
